// ===== logic/interval_timer_pkg.sv
// constants, layouts and states shared by the interval timer
// assumes a 20 MHz system clock and a 32.768 kHz crystal level on a pin
package interval_timer_pkg;
	localparam int CLK_HZ = 20_000_000;
	localparam int XTAL_HZ = 32_768;
	localparam int XTAL_HALF_CYC = CLK_HZ / (2 * XTAL_HZ);
	localparam int PRE_W = 15;
	localparam int TIMER_W = 24;
	localparam int SET_W = 11;
	// prescaler bit that runs at 1.024 kHz; bit SET_W-1 above it is 1 Hz
	localparam int DIV_LSB = 4;
	localparam logic [PRE_W-1:0] PRE_LAST = 15'h7FFF;
	localparam logic [PRE_W-1:0] PRE_RST = 15'h0000;
	localparam logic [TIMER_W-1:0] TIMER_RST = 24'h000000;
	localparam logic [SET_W-1:0] SET_RST = 11'h000;
	// serial address, arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h32;
	localparam logic [7:0] PTR_SET_LO = 8'h00;
	localparam logic [7:0] PTR_SET_HI = 8'h01;
	localparam logic [7:0] PTR_TMR_0 = 8'h02;
	localparam logic [7:0] PTR_TMR_1 = 8'h03;
	localparam logic [7:0] PTR_TMR_2 = 8'h04;
	localparam logic [3:0] BITS_BYTE = 4'h8;

	typedef struct packed {
		logic scl;
		logic sda;
	} serial_pins_s;

	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_ACK_A,
		S_WR,
		S_ACK_W,
		S_RD,
		S_RD_ACK,
		S_RD_LD
	} ser_state_e;
endpackage

// ===== logic/interval_timer.sv
// interval timer: crystal prescaler, seconds counter, gated interval output,
// two-wire serial slave for the setting and counter bytes
// assumes scl/sda/gate/crystal levels are already synchronous to clk_i
module interval_timer (
	input wire logic clk_i, // 20 MHz system clock
	input wire logic rst_i, // synchronous reset, active high
	input wire logic crystal_in_i, // crystal level
	output logic crystal_out_o, // inverted crystal drive
	input wire logic scl_i, // serial clock from host
	input wire logic sda_i, // serial data line level
	output logic sda_o, // serial data drive value
	output logic sda_oe_o, // high while pulling sda low
	input wire logic interval_gate_in_i, // interval output gate
	output logic int_o // interval output
);
	interval_timer_pkg::serial_pins_s pins_r;
	interval_timer_pkg::serial_pins_s pins_now;
	interval_timer_pkg::ser_state_e state_r;
	logic xtal_r;
	logic xtal_rise;
	logic [interval_timer_pkg::PRE_W-1:0] pre_r;
	logic sec_tick;
	logic [interval_timer_pkg::TIMER_W-1:0] timer_r;
	logic [interval_timer_pkg::SET_W-1:0] set_r;
	logic [interval_timer_pkg::SET_W-1:0] div_clk;
	logic [interval_timer_pkg::SET_W-1:0] pass;
	logic int_nxt;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	logic [3:0] cnt_r;
	logic [7:0] shift_r;
	logic [7:0] ptr_r;
	logic ptr_done_r;
	logic rw_r;
	logic [7:0] rd_byte;

	assign pins_now.scl = scl_i;
	assign pins_now.sda = sda_i;
	assign xtal_rise = crystal_in_i & ~xtal_r;
	assign sec_tick = xtal_rise && (pre_r == interval_timer_pkg::PRE_LAST);
	assign scl_rise = pins_now.scl & ~pins_r.scl;
	assign scl_fall = ~pins_now.scl & pins_r.scl;
	assign start_c = pins_now.scl & pins_r.scl & pins_r.sda & ~pins_now.sda;
	assign stop_c = pins_now.scl & pins_r.scl & ~pins_r.sda & pins_now.sda;

	// crystal edge detect and inverting drive
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			xtal_r <= 1'b0;
			crystal_out_o <= 1'b1;
		end else begin
			xtal_r <= crystal_in_i;
			crystal_out_o <= ~crystal_in_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pre_r <= interval_timer_pkg::PRE_RST;
		end else if (xtal_rise) begin
			pre_r <= pre_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			timer_r <= interval_timer_pkg::TIMER_RST;
		end else if (sec_tick) begin
			timer_r <= timer_r + 1'b1;
		end
	end

	genvar g;
	generate
		for (g = 0; g < interval_timer_pkg::SET_W; g++) begin : g_div
			assign div_clk[g] = pre_r[interval_timer_pkg::DIV_LSB + g];
			assign pass[g] = div_clk[g] | ~set_r[g];
		end
	endgenerate

	// gated AND of selected clocks, low when nothing selected
	assign int_nxt = interval_gate_in_i & (|set_r) & (&pass);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_o <= 1'b0;
		end else begin
			int_o <= int_nxt;
		end
	end

	// readback byte for the current pointer
	always_comb begin
		case (ptr_r)
			interval_timer_pkg::PTR_SET_LO: rd_byte = set_r[7:0];
			interval_timer_pkg::PTR_SET_HI: rd_byte = {5'h00, set_r[10:8]};
			interval_timer_pkg::PTR_TMR_0: rd_byte = timer_r[7:0];
			interval_timer_pkg::PTR_TMR_1: rd_byte = timer_r[15:8];
			interval_timer_pkg::PTR_TMR_2: rd_byte = timer_r[23:16];
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pins_r <= '{scl: 1'b1, sda: 1'b1};
		end else begin
			pins_r <= pins_now;
		end
	end

	always_ff @(posedge clk_i) begin
		sda_o <= 1'b0;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= interval_timer_pkg::S_IDLE;
			cnt_r <= 4'h0;
			shift_r <= 8'h00;
			rw_r <= 1'b0;
			sda_oe_o <= 1'b0;
		end else if (stop_c) begin
			state_r <= interval_timer_pkg::S_IDLE;
			sda_oe_o <= 1'b0;
		end else if (start_c) begin
			state_r <= interval_timer_pkg::S_ADDR;
			cnt_r <= 4'h0;
			sda_oe_o <= 1'b0;
		end else if (scl_rise) begin
			case (state_r)
				interval_timer_pkg::S_ADDR, interval_timer_pkg::S_WR: begin
					shift_r <= {shift_r[6:0], pins_now.sda};
					cnt_r <= cnt_r + 1'b1;
				end
				interval_timer_pkg::S_RD: begin
					shift_r <= {shift_r[6:0], 1'b0};
					cnt_r <= cnt_r + 1'b1;
				end
				interval_timer_pkg::S_RD_ACK: begin
					state_r <= pins_now.sda ? interval_timer_pkg::S_IDLE
						: interval_timer_pkg::S_RD_LD;
				end
				default: begin
				end
			endcase
		end else if (scl_fall) begin
			case (state_r)
				interval_timer_pkg::S_ADDR: begin
					if (cnt_r == interval_timer_pkg::BITS_BYTE) begin
						if (shift_r[7:1] == interval_timer_pkg::DEV_ADDR) begin
							state_r <= interval_timer_pkg::S_ACK_A;
							rw_r <= shift_r[0];
							sda_oe_o <= 1'b1;
						end else begin
							state_r <= interval_timer_pkg::S_IDLE;
						end
					end
				end
				interval_timer_pkg::S_ACK_A, interval_timer_pkg::S_RD_LD: begin
					cnt_r <= 4'h0;
					if (rw_r) begin
						state_r <= interval_timer_pkg::S_RD;
						shift_r <= rd_byte;
						sda_oe_o <= ~rd_byte[7];
					end else begin
						state_r <= interval_timer_pkg::S_WR;
						sda_oe_o <= 1'b0;
					end
				end
				interval_timer_pkg::S_WR: begin
					if (cnt_r == interval_timer_pkg::BITS_BYTE) begin
						state_r <= interval_timer_pkg::S_ACK_W;
						sda_oe_o <= 1'b1;
					end
				end
				interval_timer_pkg::S_ACK_W: begin
					state_r <= interval_timer_pkg::S_WR;
					cnt_r <= 4'h0;
					sda_oe_o <= 1'b0;
				end
				interval_timer_pkg::S_RD: begin
					if (cnt_r == interval_timer_pkg::BITS_BYTE) begin
						state_r <= interval_timer_pkg::S_RD_ACK;
						sda_oe_o <= 1'b0;
					end else begin
						sda_oe_o <= ~shift_r[7];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// pointer and setting writes, pointer steps per byte
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ptr_r <= interval_timer_pkg::PTR_SET_LO;
			ptr_done_r <= 1'b0;
			set_r <= interval_timer_pkg::SET_RST;
		end else if (start_c) begin
			ptr_done_r <= 1'b0;
		end else if (scl_fall && state_r == interval_timer_pkg::S_WR
			&& cnt_r == interval_timer_pkg::BITS_BYTE) begin
			if (!ptr_done_r) begin
				ptr_r <= shift_r;
				ptr_done_r <= 1'b1;
			end else begin
				ptr_r <= ptr_r + 1'b1;
				if (ptr_r == interval_timer_pkg::PTR_SET_LO) begin
					set_r[7:0] <= shift_r;
				end else if (ptr_r == interval_timer_pkg::PTR_SET_HI) begin
					set_r[10:8] <= shift_r[2:0];
				end
			end
		end else if (scl_rise && state_r == interval_timer_pkg::S_RD_ACK) begin
			ptr_r <= ptr_r + 1'b1;
		end
	end

	// checks
	sequence xtal_edge_s;
		crystal_in_i && !xtal_r;
	endsequence

	sequence last_step_s;
		xtal_edge_s ##0 (pre_r == interval_timer_pkg::PRE_LAST);
	endsequence

	a_prescaler_step: assert property (@(posedge clk_i) disable iff (rst_i)
		xtal_edge_s |=> pre_r == $past(pre_r) + 1'b1)
		else $error("prescaler did not step on crystal edge");

	a_prescaler_still: assert property (@(posedge clk_i) disable iff (rst_i)
		!(crystal_in_i && !xtal_r) |=> $stable(pre_r))
		else $error("prescaler moved without crystal edge");

	a_second_count: assert property (@(posedge clk_i) disable iff (rst_i)
		last_step_s |=> timer_r == $past(timer_r) + 1'b1)
		else $error("seconds counter missed a tick");

	a_timer_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!(crystal_in_i && !xtal_r && pre_r == interval_timer_pkg::PRE_LAST)
		|=> $stable(timer_r))
		else $error("seconds counter moved off tick");

	a_sda_low_only: assert property (@(posedge clk_i) disable iff (rst_i)
		sda_oe_o |-> !sda_o)
		else $error("sda driven high");

	a_gate_low_hold: assert property (@(posedge clk_i) disable iff (rst_i)
		!interval_gate_in_i |=> !int_o)
		else $error("interval output active with gate low");

	a_zero_setting: assert property (@(posedge clk_i) disable iff (rst_i)
		set_r == interval_timer_pkg::SET_RST |=> !int_o)
		else $error("interval output high with empty setting");

	a_and_select: assert property (@(posedge clk_i) disable iff (rst_i)
		interval_gate_in_i && (|set_r)
		|=> int_o == &$past(pass))
		else $error("interval output is not AND of selected clocks");

	a_addr_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		scl_fall && !start_c && !stop_c && state_r == interval_timer_pkg::S_ADDR
		&& cnt_r == interval_timer_pkg::BITS_BYTE
		&& shift_r[7:1] == interval_timer_pkg::DEV_ADDR
		|=> sda_oe_o && state_r == interval_timer_pkg::S_ACK_A)
		else $error("matching address not acknowledged");

	a_setting_write: assert property (@(posedge clk_i) disable iff (rst_i)
		scl_fall && !start_c && !stop_c && state_r == interval_timer_pkg::S_WR
		&& cnt_r == interval_timer_pkg::BITS_BYTE && ptr_done_r
		&& ptr_r == interval_timer_pkg::PTR_SET_LO
		|=> set_r[7:0] == $past(shift_r))
		else $error("setting byte not stored");
endmodule

// ===== verification/serial_host.sv
// host side of the two-wire bus: drives the serial clock and pulls data low
// assumes the bench resolves the data wire with a pull-up from both enables
module serial_host (
	input wire logic clk_i, // system clock
	input wire logic sda_i, // resolved data wire level
	output logic scl_o, // serial clock
	output logic pull_o // high while pulling data low
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	task automatic half();
		repeat (3) @(negedge clk_i);
	endtask
	task automatic bit_io(input logic b, output logic r);
		pull_o = ~b;
		half();
		scl_o = 1'b1;
		half();
		r = sda_i;
		scl_o = 1'b0;
		half();
	endtask
	task automatic start();
		pull_o = 1'b0;
		half();
		pull_o = 1'b1;
		half();
		scl_o = 1'b0;
		half();
	endtask
	task automatic stop();
		pull_o = 1'b1;
		half();
		scl_o = 1'b1;
		half();
		pull_o = 1'b0;
		half();
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, ack);
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, r);
	endtask
endmodule

// ===== verification/interval_timer_test.sv
// self-checking bench: random settings, duty counts, serial read-back
// assumes a crystal level toggled each clock to shorten the second
module interval_timer_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 1'b0, rst_i = 1'b1, crystal_in_i = 1'b0, gate = 1'b0;
	logic scl, pull, sda, sda_o, sda_oe_o, crystal_out_o, int_o, xprev, ack;
	logic [7:0] d;
	logic [10:0] s;
	int err_total = 0, n_tests = 0, cyc = 0, seed = 34402;
	assign sda = ~(pull | sda_oe_o);
	interval_timer u_interval_timer (.clk_i(clk_i), .rst_i(rst_i),
		.crystal_in_i(crystal_in_i), .crystal_out_o(crystal_out_o), .scl_i(scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.interval_gate_in_i(gate), .int_o(int_o));
	serial_host u_serial_host (.clk_i(clk_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));
	initial forever #25 clk_i = ~clk_i;
	always @(negedge clk_i) if (!rst_i) crystal_in_i <= ~crystal_in_i;
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("mismatches %0d comparisons %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc++;
		xprev <= crystal_in_i;
		if (cyc > 4) begin
			check(crystal_out_o, {~xprev});
			if (sda_oe_o === 1'b1) check(sda_o, 1'b0);
		end
		if (cyc == 100000) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic wr(input logic [7:0] b);
		u_serial_host.wbyte(b, ack);
		check(ack, 1'b0);
	endtask
	task automatic set_write(input logic [10:0] v);
		u_serial_host.start();
		wr({interval_timer_pkg::DEV_ADDR, 1'b0});
		wr(interval_timer_pkg::PTR_SET_LO);
		wr(v[7:0]);
		wr({5'h00, v[10:8]});
		u_serial_host.stop();
	endtask
	// two-byte read: master ack on the first byte, nack on the second
	task automatic rd(input logic [7:0] p, input logic [7:0] exp, input logic [7:0] exp_next);
		u_serial_host.start();
		wr({interval_timer_pkg::DEV_ADDR, 1'b0});
		wr(p);
		u_serial_host.stop();
		u_serial_host.start();
		wr({interval_timer_pkg::DEV_ADDR, 1'b1});
		u_serial_host.rbyte(1'b0, d);
		check(d, exp);
		u_serial_host.rbyte(1'b1, d);
		u_serial_host.stop();
		check(d, exp_next);
	endtask
	// high clocks over one full period of the slowest selected clock
	function automatic int exp_high(input logic [10:0] v, input logic g);
		int top = 0, pop = 0;
		for (int k = 0; k < 11; k++) if (v[k]) begin
			top = k;
			pop++;
		end
		return (g && v != 11'h000) ? 1 << (top + 6 - pop) : 0;
	endfunction
	task automatic duty(input logic [10:0] v, input logic g);
		int top = 0, hi = 0;
		set_write(v);
		gate = g;
		for (int k = 0; k < 11; k++) if (v[k]) top = k;
		repeat (8) @(negedge clk_i);
		repeat (1 << (top + 6)) begin
			@(negedge clk_i);
			if (int_o === 1'b1) hi++;
		end
		check(hi[15:0], 16'(exp_high(v, g)));
	endtask
	initial begin
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		@(negedge clk_i);
		check(int_o, 1'b0);
		duty(11'h000, 1'b1);
		duty(11'h01E, 1'b1);
		duty(11'h01E, 1'b0);
		for (int i = 0; i < 6; i++) begin
			s = {6'h00, 5'($random(seed))};
			duty(s, 1'($random(seed)));
		end
		rd(interval_timer_pkg::PTR_SET_LO, s[7:0], {5'h00, s[10:8]});
		rd(interval_timer_pkg::PTR_SET_HI, 8'h00, 8'h00);
		u_serial_host.start();
		u_serial_host.wbyte({interval_timer_pkg::DEV_ADDR ^ 7'h01, 1'b0}, ack);
		u_serial_host.stop();
		check(ack, 1'b1);
		while (cyc < 70000) @(negedge clk_i);
		rd(interval_timer_pkg::PTR_TMR_0, 8'h01, 8'h00);
		rd(interval_timer_pkg::PTR_TMR_1, 8'h00, 8'h00);
		tally_and_finish();
	end
endmodule
